// ### tci_pkg.sv
// Package with constants and types for the test charge injection controller
package tci_pkg;
	// ==========================================================
	// Sizes
	localparam int          TCI_NUM_CH    = 18;
	localparam int          TCI_DAC_W     = 4;
	localparam int          TCI_BYTE_W    = 8;
	// ==========================================================
	// Addressing
	localparam logic [6:0]  TCI_DEV_ADDR  = 7'h2A;
	localparam logic [7:0]  TCI_REG_EN0   = 8'h00;
	localparam logic [7:0]  TCI_REG_EN1   = 8'h01;
	localparam logic [7:0]  TCI_REG_EN2   = 8'h02;
	localparam logic [7:0]  TCI_REG_DAC   = 8'h03;
	localparam logic [7:0]  TCI_REG_LAST  = 8'h03;
	// ==========================================================
	// Reset values
	localparam logic [17:0] TCI_EN_RST    = 18'h00000;
	localparam logic [3:0]  TCI_DAC_RST   = 4'h0;
	localparam logic [3:0]  TCI_BITCNT_RST = 4'h0;

	typedef enum logic [2:0] {
		TCI_IDLE,
		TCI_ADDR,
		TCI_ACK,
		TCI_DATA,
		TCI_IGNORE
	} tci_state_t;
endpackage

// ### tci_bit_sampler.sv
// Two-wire line sampler with start, stop and clock-edge detection
`timescale 1ns/10ps
`default_nettype none
module tci_bit_sampler (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic clk_en,
	// Serial lines
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Events and data bit
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_det,
	output logic      stop_det,
	output logic      sda_bit
);
	import tci_pkg::*;

	typedef struct packed {
		logic scl;
		logic sda;
	} tci_smp_t;

	tci_smp_t s_q;
	tci_smp_t s_d;

	always_comb begin
		s_d     = s_q;
		s_d.scl = scl_in;
		s_d.sda = sda_in;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_q <= '{scl: 1'b1, sda: 1'b1};
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign scl_rise  = clk_en & scl_in & ~s_q.scl;
	assign scl_fall  = clk_en & ~scl_in & s_q.scl;
	assign start_det = clk_en & scl_in & s_q.scl & s_q.sda & ~sda_in;
	assign stop_det  = clk_en & scl_in & s_q.scl & ~s_q.sda & sda_in;
	assign sda_bit   = sda_in;
endmodule
`default_nettype wire

// ### tci_ctrl.sv
// Test charge injection controller: two-wire slave with channel enables and DAC code
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1: Each channel has its own enable bit; any subset may be selected.
// R2: A 4-bit DAC code sets the injected charge size.
// R3: Channel enables are written by a tester over a two-wire serial slave.
// R4: The DAC code is written over that same two-wire interface.
// R5: The system holds the test clock low in normal use, idling the logic.
// R6: Eighteen channel enables, one per preamplifier channel.
// R7: Disabled channels never get charge; enables clear at reset.
module tci_ctrl (
	// Clock and reset
	input  wire logic                             sys_clk,
	input  wire logic                             rstn,
	input  wire logic                             clk_en,
	// Two-wire serial
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out,
	output logic                                  sda_oe,
	// Analog side
	output logic [tci_pkg::TCI_NUM_CH-1:0]        chan_inject_en,
	output logic [tci_pkg::TCI_DAC_W-1:0]         dac_code,
	// Status
	output logic                                  busy
);
	import tci_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		tci_state_t             st;
		logic [3:0]             bitcnt;
		logic [7:0]             shreg;
		logic                   have_ptr;
		logic [7:0]             ptr;
		logic                   ack_drv;
		logic [TCI_NUM_CH-1:0]  en;
		logic [TCI_DAC_W-1:0]   dac;
	} tci_ctrl_t;

	tci_ctrl_t q;
	tci_ctrl_t d;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic sda_bit;

	tci_bit_sampler u_smp (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.clk_en    (clk_en),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det),
		.sda_bit   (sda_bit)
	);

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		if (start_det) begin
			d.st       = TCI_ADDR;
			d.bitcnt   = TCI_BITCNT_RST;
			d.have_ptr = 1'b0;
			d.ack_drv  = 1'b0;
		end else if (stop_det) begin
			d.st      = TCI_IDLE;
			d.ack_drv = 1'b0;
		end else begin
			case (q.st)
				TCI_IDLE: begin
					d.ack_drv = 1'b0;
				end
				TCI_ADDR, TCI_DATA: begin
					if (scl_rise) begin
						d.shreg  = {q.shreg[6:0], sda_bit};
						d.bitcnt = q.bitcnt + 4'h1;
					end
					if (scl_fall && q.bitcnt == 4'h8) begin
						d.bitcnt = TCI_BITCNT_RST;
						if (q.st == TCI_ADDR) begin
							// R3: Answer only own write address
							if (q.shreg[7:1] == TCI_DEV_ADDR && !q.shreg[0]) begin
								d.ack_drv = 1'b1;
								d.st      = TCI_ACK;
							end else begin
								d.st = TCI_IGNORE;
							end
						end else if (!q.have_ptr) begin
							d.ptr      = q.shreg;
							d.have_ptr = 1'b1;
							d.ack_drv  = 1'b1;
							d.st       = TCI_ACK;
						end else begin
							// R1: Per-channel enable bytes
							// R4: DAC on same interface
							case (q.ptr)
								TCI_REG_EN0: d.en[7:0]   = q.shreg;
								TCI_REG_EN1: d.en[15:8]  = q.shreg;
								TCI_REG_EN2: d.en[17:16] = q.shreg[1:0];
								TCI_REG_DAC: d.dac       = q.shreg[3:0];
								default:     d.dac       = q.dac;
							endcase
							d.ptr     = (q.ptr == TCI_REG_LAST) ? TCI_REG_EN0 : q.ptr + 8'h01;
							d.ack_drv = (q.ptr <= TCI_REG_LAST);
							d.st      = TCI_ACK;
						end
					end
				end
				TCI_ACK: begin
					if (scl_fall) begin
						d.ack_drv = 1'b0;
						d.st      = TCI_DATA;
					end
				end
				TCI_IGNORE: begin
					d.ack_drv = 1'b0;
				end
				default: begin
					d.st = TCI_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	// R5: Stalled clock enable freezes everything
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q.st       <= TCI_IDLE;
			q.bitcnt   <= TCI_BITCNT_RST;
			q.shreg    <= 8'h00;
			q.have_ptr <= 1'b0;
			q.ptr      <= TCI_REG_EN0;
			q.ack_drv  <= 1'b0;
			// R7: Enables cleared at reset
			q.en       <= TCI_EN_RST;
			q.dac      <= TCI_DAC_RST;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign sda_out = 1'b0;
	assign sda_oe  = q.ack_drv;
	assign busy    = (q.st != TCI_IDLE) && (q.st != TCI_IGNORE);

	// R6: One gate per channel
	// R7: Disabled channels get no charge
	genvar g;
	generate
		for (g = 0; g < TCI_NUM_CH; g = g + 1) begin : g_ch
			assign chan_inject_en[g] = q.en[g];
		end
	endgenerate

	// R2: Four-bit charge code
	assign dac_code = q.dac;
endmodule
`default_nettype wire

// ### tci_ctrl_checker.sv
// Port assertions for the controller
`timescale 1ns/10ps
`default_nettype none
module tci_ctrl_checker (
	// Watched ports
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        clk_en,
	input wire logic        scl_in,
	input wire logic        sda_oe,
	input wire logic [17:0] chan_inject_en,
	input wire logic [3:0]  dac_code,
	input wire logic        busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	rst_clear_a: assert property (disable iff (1'b0) !rstn |=> !sda_oe && chan_inject_en == 0 && dac_code == 0)
		else $error("Reset left state");
	frozen_a: assert property (!clk_en |=> $stable(chan_inject_en) && $stable(dac_code))
		else $error("Changed while stopped");
	en_busy_a: assert property ($changed(chan_inject_en) && $past(rstn) |-> busy)
		else $error("Enables moved when idle");
	dac_busy_a: assert property ($changed(dac_code) && $past(rstn) |-> busy)
		else $error("Code moved when idle");
	ack_busy_a: assert property (sda_oe |-> busy)
		else $error("Pull outside transfer");
	ack_low_a: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("Pull began with clock high");
	ack_hold_a: assert property (sda_oe && scl_in |=> sda_oe)
		else $error("Pull dropped early");
endmodule
bind tci_ctrl tci_ctrl_checker tci_ctrl_checker_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
	.scl_in(scl_in), .sda_oe(sda_oe), .chan_inject_en(chan_inject_en), .dac_code(dac_code), .busy(busy));
`default_nettype wire

// ### tci_tester.sv
// Tester model: two-wire master with pulled-up data line
`timescale 1ns/10ps
`default_nettype none
module tci_tester (
	// Lines
	input  wire logic sys_clk,
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda
);
	logic sda_q = 1'b1;
	initial scl = 1'b1;
	// Pull-up resolves both drivers
	assign sda = sda_q & ~sda_oe;
	// Each phase lasts two cycles
	task automatic tick(input logic c, input logic d);
		@(posedge sys_clk);
		scl <= c;
		sda_q <= d;
		@(posedge sys_clk);
	endtask
	task automatic start();
		tick(1'b1, 1'b1);
		tick(1'b1, 1'b0);
	endtask
	task automatic stop();
		tick(1'b0, sda_q);
		tick(1'b0, 1'b0);
		tick(1'b1, 1'b0);
		tick(1'b1, 1'b1);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			tick(1'b0, sda_q);
			tick(1'b0, b[i]);
			tick(1'b1, b[i]);
		end
		tick(1'b0, sda_q);
		tick(1'b0, 1'b1);
		tick(1'b1, 1'b1);
		#1 ack = ~sda;
	endtask
endmodule
`default_nettype wire

// ### tci_ctrl_tb_top.sv
// Testbench for the test charge injection controller
`timescale 1ns/10ps
`default_nettype none
module tci_ctrl_tb_top;
	import tci_pkg::*;
	localparam logic [7:0] dev_wr = {TCI_DEV_ADDR, 1'b0};
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        clk_en = 1'b1;
	logic        scl, sda, sda_oe, busy, ack, sda_o;
	logic [17:0] en;
	logic [3:0]  dac;
	int          num_errors = 0;
	int          total_checks = 0;
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	tci_tester tci_tester_inst (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	tci_ctrl tci_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe(sda_oe), .chan_inject_en(en), .dac_code(dac), .busy(busy));
	task automatic chk(input logic [21:0] got, input logic [21:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Start, address, then n bytes, stop; ak[4] address ack, ak[3-i] byte i ack
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n, input logic [4:0] ak);
		tci_tester_inst.start();
		tci_tester_inst.send(a, ack);
		chk({21'h0, ack}, {21'h0, ak[4]});
		chk({21'h0, busy}, {21'h0, ak[4]});
		for (int i = 0; i < n; i++) begin
			tci_tester_inst.send(d[31-8*i -: 8], ack);
			chk({21'h0, ack}, {21'h0, ak[3-i]});
		end
		tci_tester_inst.stop();
		@(posedge sys_clk);
		chk({21'h0, busy}, 22'h0);
	endtask
	task automatic stop_test();
		$display("Checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({en, dac}, 22'h0);
		wr(dev_wr, {TCI_REG_EN0, 24'h5AC302}, 4, 5'h1F);
		wr(dev_wr, {TCI_REG_DAC, 8'h0F, 8'hFF, 8'h0}, 3, 5'h1F);
		chk({en, dac}, {18'h2C3FF, 4'hF});
		wr(dev_wr, {8'h05, 8'h77, 16'h0}, 2, 5'h18);
		chk({en, dac}, {18'h2C3FF, 4'hF});
		$display("Test write and wrap done");
		wr({TCI_DEV_ADDR ^ 7'h01, 1'b0}, {TCI_REG_EN0, 24'h0}, 2, 5'h00);
		clk_en <= 1'b0;
		wr(dev_wr, {TCI_REG_DAC, 24'h0}, 2, 5'h00);
		clk_en <= 1'b1;
		chk({en, dac}, {18'h2C3FF, 4'hF});
		$display("Test refusal and freeze done");
		rstn <= 1'b0;
		@(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({en, dac}, 22'h0);
		chk({21'h0, sda_o}, 22'h0);
		$display("Test reset done");
		stop_test();
	end
endmodule
`default_nettype wire
